// file: inc/usb_ep_pkg.sv
/*
  Package for the endpoint FIFO, byte count, flush and interrupt registers.
  Assumes an 8-bit special function register port on the core clock.
*/
package usb_ep_pkg;
  localparam int unsigned  EP_COUNT      = 7;
  localparam int unsigned  EP_IDX_W      = 3;
  localparam int unsigned  FIFO_DEPTH    = 128;
  localparam int unsigned  PTR_W         = 7;
  localparam logic [7:0]   ADDR_IRQ_EN   = 8'hc2;
  localparam logic [7:0]   ADDR_FIFO     = 8'hcf;
  localparam logic [7:0]   ADDR_FLUSH    = 8'hd5;
  localparam logic [7:0]   ADDR_BYTE_CNT = 8'he2;
  localparam logic [7:0]   ADDR_IRQ_FLAG = 8'hf8;
  localparam logic [6:0]   EP_RESET_VAL  = 7'h00;
  localparam logic [7:0]   BYTE_ZERO     = 8'h00;
  localparam logic [PTR_W-1:0] PTR_ZERO  = 7'h00;

  // status sources of one endpoint
  typedef struct packed {
    logic stall_or_crc_flag;
    logic setup_seen_flag;
    logic out_bank_b_flag;
    logic out_bank_a_flag;
    logic in_done_flag;
  } ep_status_s;

  // one special function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // packet engine side access to the fifo of one endpoint
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [EP_IDX_W-1:0] ep;
    logic [7:0]          wdata;
  } eng_req_s;
endpackage : usb_ep_pkg

// file: rtl/usb_ep_regs.sv
/*
  Endpoint register block: fifo port, byte count, fifo flush, interrupt
  flags and enables, with one fifo per endpoint.
  Assumes the core drives single-cycle sfr strobes and the packet engine
  supplies status, received counts and its own fifo accesses.
*/
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module usb_ep_regs (
  input  wire logic                                mclk,
  input  wire logic                                arst_n,
  input  wire usb_ep_pkg::sfr_req_s                sfr,
  input  wire logic [usb_ep_pkg::EP_IDX_W-1:0]     endpoint_select,
  input  wire usb_ep_pkg::ep_status_s              status [usb_ep_pkg::EP_COUNT],
  input  wire logic                                setup_valid,
  input  wire logic [usb_ep_pkg::EP_IDX_W-1:0]     setup_ep,
  input  wire logic                                pkt_done,
  input  wire logic [usb_ep_pkg::EP_IDX_W-1:0]     pkt_ep,
  input  wire logic [6:0]                          pkt_len,
  input  wire usb_ep_pkg::eng_req_s                eng,
  output logic [7:0]                               sfr_rdata,
  output logic [7:0]                               eng_rdata,
  output logic [usb_ep_pkg::EP_COUNT-1:0]          ep_flush,
  output logic                                     setup_clear,
  output logic [usb_ep_pkg::EP_IDX_W-1:0]          setup_clear_ep,
  output logic                                     usb_irq
);
  // endpoint number width, local so it can size a cast
  localparam int unsigned EP_W = usb_ep_pkg::EP_IDX_W;

  //////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]                      fifo_mem [usb_ep_pkg::EP_COUNT][usb_ep_pkg::FIFO_DEPTH];
  logic [usb_ep_pkg::PTR_W-1:0]    cpu_ptr  [usb_ep_pkg::EP_COUNT];
  logic [usb_ep_pkg::PTR_W-1:0]    eng_ptr  [usb_ep_pkg::EP_COUNT];
  logic [6:0]                      packet_length [usb_ep_pkg::EP_COUNT];
  logic [6:0]                      endpoint_irq_enable;
  logic [6:0]                      endpoint_fifo_flush;
  logic [usb_ep_pkg::EP_COUNT-1:0] endpoint_irq_flags;
  logic [7:0]                      next_rdata;

  logic hit_fifo;
  logic hit_flush;
  logic hit_en;
  assign hit_fifo  = sfr.addr == usb_ep_pkg::ADDR_FIFO;
  assign hit_flush = sfr.addr == usb_ep_pkg::ADDR_FLUSH;
  assign hit_en    = sfr.addr == usb_ep_pkg::ADDR_IRQ_EN;

  //////////////////////////////////////////////////////////////////////////
  // summary flags per endpoint
  usb_ep_status u_status (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .status  (status),
    .summary (endpoint_irq_flags)
  );

  //////////////////////////////////////////////////////////////////////////
  // flush and enable registers, bit 7 not stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      endpoint_fifo_flush <= usb_ep_pkg::EP_RESET_VAL;
    end else if (sfr.wr && hit_flush) begin
      endpoint_fifo_flush <= sfr.wdata[6:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      endpoint_irq_enable <= usb_ep_pkg::EP_RESET_VAL;
    end else if (sfr.wr && hit_en) begin
      endpoint_irq_enable <= sfr.wdata[6:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ep_flush <= usb_ep_pkg::EP_RESET_VAL;
    end else begin
      ep_flush <= endpoint_fifo_flush;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt output: flag and enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= |(endpoint_irq_flags & endpoint_irq_enable);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // setup: request clear of the other status bits of that endpoint
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      setup_clear    <= 1'b0;
      setup_clear_ep <= '0;
    end else begin
      setup_clear    <= setup_valid;
      setup_clear_ep <= setup_ep;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-endpoint pointers, byte counts, fifo storage
  genvar g;
  for (g = 0; g < usb_ep_pkg::EP_COUNT; g++) begin : g_ep
    localparam logic [EP_W-1:0] EP_NUM = EP_W'(g); // this slot's endpoint number
    logic cpu_hit;
    logic eng_hit;
    assign cpu_hit = endpoint_select == EP_NUM && hit_fifo;
    assign eng_hit = eng.ep == EP_NUM;

    // core-side pointer, advanced by every fifo port access while the endpoint's flush bit is clear
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cpu_ptr[g] <= usb_ep_pkg::PTR_ZERO;
      end else if (endpoint_fifo_flush[g]) begin
        cpu_ptr[g] <= usb_ep_pkg::PTR_ZERO;
      end else if (cpu_hit && (sfr.wr || sfr.rd)) begin
        cpu_ptr[g] <= cpu_ptr[g] + 7'h01;
      end
    end

    // engine-side pointer
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        eng_ptr[g] <= usb_ep_pkg::PTR_ZERO;
      end else if (endpoint_fifo_flush[g]) begin
        eng_ptr[g] <= usb_ep_pkg::PTR_ZERO;
      end else if (eng_hit && (eng.wr || eng.rd)) begin
        eng_ptr[g] <= eng_ptr[g] + 7'h01;
      end
    end

    // received byte count per endpoint
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        packet_length[g] <= usb_ep_pkg::EP_RESET_VAL;
      end else if (endpoint_fifo_flush[g]) begin
        packet_length[g] <= usb_ep_pkg::EP_RESET_VAL;
      end else if (pkt_done && pkt_ep == EP_NUM) begin
        packet_length[g] <= pkt_len;
      end
    end

    // fifo storage has no reset, content undefined until written
    always_ff @(posedge mclk) begin
      if (cpu_hit && sfr.wr && !endpoint_fifo_flush[g]) begin
        fifo_mem[g][cpu_ptr[g]] <= sfr.wdata;
      end else if (eng_hit && eng.wr && !endpoint_fifo_flush[g]) begin
        fifo_mem[g][eng_ptr[g]] <= eng.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data mux
  always_comb begin
    next_rdata = usb_ep_pkg::BYTE_ZERO;
    unique case (sfr.addr)
      usb_ep_pkg::ADDR_FIFO:     next_rdata = fifo_mem[endpoint_select][cpu_ptr[endpoint_select]];
      usb_ep_pkg::ADDR_BYTE_CNT: next_rdata = {1'b0, packet_length[endpoint_select]};
      usb_ep_pkg::ADDR_FLUSH:    next_rdata = {1'b0, endpoint_fifo_flush};
      usb_ep_pkg::ADDR_IRQ_FLAG: next_rdata = {1'b0, endpoint_irq_flags};
      usb_ep_pkg::ADDR_IRQ_EN:   next_rdata = {1'b0, endpoint_irq_enable};
      default:                   next_rdata = usb_ep_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= usb_ep_pkg::BYTE_ZERO;
    end else if (sfr.rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eng_rdata <= usb_ep_pkg::BYTE_ZERO;
    end else if (eng.rd) begin
      eng_rdata <= fifo_mem[eng.ep][eng_ptr[eng.ep]];
    end
  end
endmodule : usb_ep_regs

// file: rtl/usb_ep_status.sv
/*
  Per-endpoint status summary: ors the five sources of each endpoint.
  Assumes status sources come from the packet engine on the same clock.
*/
`timescale 1ns/1ps
module usb_ep_status (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire usb_ep_pkg::ep_status_s status [usb_ep_pkg::EP_COUNT],
  output logic [usb_ep_pkg::EP_COUNT-1:0] summary
);
  // summary flag per endpoint, clears when all sources are clear
  genvar g;
  for (g = 0; g < usb_ep_pkg::EP_COUNT; g++) begin : g_ep
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        summary[g] <= 1'b0;
      end else begin
        summary[g] <= |status[g];
      end
    end
  end
endmodule : usb_ep_status

// file: testbench/usb_ep_regs_assertions.sv
/* port checker for the endpoint register block.
   assumes one clock mclk and async active-low arst_n. */
`timescale 1ns/1ps
module usb_ep_regs_assertions (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire usb_ep_pkg::sfr_req_s   sfr,
  input wire usb_ep_pkg::ep_status_s status [usb_ep_pkg::EP_COUNT],
  input wire logic                   setup_valid,
  input wire logic [2:0]             setup_ep,
  input wire logic [7:0]             sfr_rdata,
  input wire logic [6:0]             ep_flush,
  input wire logic                   setup_clear,
  input wire logic [2:0]             setup_clear_ep,
  input wire logic                   usb_irq
);
  logic [6:0] srcs;
  // any source set, per endpoint
  always_comb for (int i = 0; i < 7; i++) srcs[i] = |status[i];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  sequence s_rd(a); sfr.rd && sfr.addr == a; endsequence
  sequence s_settled; $stable(srcs)[*3]; endsequence
  property p_flags; s_settled ##0 s_rd(8'hf8) |=> sfr_rdata == {1'b0, $past(srcs)}; endproperty
  property p_quiet; (srcs == 7'h00)[*3] |-> !usb_irq; endproperty
  property p_cause; usb_irq |-> $past(srcs, 2) != 7'h00; endproperty
  property p_rsvd; s_rd(8'hc2) or s_rd(8'hd5) or s_rd(8'he2) or s_rd(8'hf8) |=> !sfr_rdata[7];
  endproperty
  property p_unmap;
    sfr.rd && !(sfr.addr inside {8'hc2, 8'hcf, 8'hd5, 8'he2, 8'hf8}) |=> sfr_rdata == 8'h00;
  endproperty
  property p_hold; !sfr.rd |=> $stable(sfr_rdata); endproperty
  property p_flush;
    sfr.wr && sfr.addr == 8'hd5 |-> ##2 {1'b0, ep_flush} == ($past(sfr.wdata, 2) & 8'h7f);
  endproperty
  property p_setup; setup_valid |=> setup_clear && setup_clear_ep == $past(setup_ep); endproperty
  a_flags: assert property (p_flags) else $error("flags");
  a_quiet: assert property (p_quiet) else $error("irq quiet");
  a_cause: assert property (p_cause) else $error("irq cause");
  a_rsvd: assert property (p_rsvd) else $error("bit 7");
  a_unmap: assert property (p_unmap) else $error("unmapped");
  a_hold: assert property (p_hold) else $error("read hold");
  a_flush: assert property (p_flush) else $error("flush");
  a_setup: assert property (p_setup) else $error("setup");
endmodule : usb_ep_regs_assertions

// file: testbench/usb_ep_regs_tb_top.sv
/* bench for the endpoint register block against a reference model.
   assumes the engine model answers on the far side. */
`timescale 1ns/1ps
module usb_ep_regs_tb_top;
  logic mclk, arst_n, setup_valid, pkt_done, setup_clear, usb_irq;
  logic [2:0] endpoint_select, setup_ep, pkt_ep, setup_clear_ep;
  logic [6:0] pkt_len, ep_flush, en;
  logic [7:0] sfr_rdata, eng_rdata, q, d, mem[7][128];
  logic [7:0] regs[5] = '{8'hc2, 8'hd5, 8'he2, 8'hf8, 8'h80};
  logic [7:0] rexp[5] = '{8'h7f, 8'h7f, 8'h00, 8'h00, 8'h00};
  usb_ep_pkg::sfr_req_s sfr;
  usb_ep_pkg::eng_req_s eng;
  usb_ep_pkg::ep_status_s status [usb_ep_pkg::EP_COUNT];
  int failures, comparisons, n, cp[7], hp[7], cnt[7];
  ////////////////////////////////////////
  usb_ep_regs usb_ep_regs_i (.mclk, .arst_n, .sfr, .endpoint_select, .status, .setup_valid,
    .setup_ep, .pkt_done, .pkt_ep, .pkt_len, .eng, .sfr_rdata, .eng_rdata, .ep_flush,
    .setup_clear, .setup_clear_ep, .usb_irq);
  usb_host_model usb_host_model_i (.mclk, .setup_clear, .setup_clear_ep, .eng_rdata, .status,
    .setup_valid, .setup_ep, .pkt_done, .pkt_ep, .pkt_len, .eng);
  // clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // compare one byte
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // register access, read data a cycle later
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfr = {w, ~w, a, v};
    @(negedge mclk);
    sfr = {2'b00, a, ~v};
    q = sfr_rdata;
  endtask : acc
  // flush write and model pointer rewind
  task automatic flush(input logic [6:0] m);
    acc(1'b1, 8'hd5, {1'b0, m});
    for (int i = 0; i < 7; i++) if (m[i]) {cp[i], hp[i], cnt[i]} = '0;
  endtask : flush
  function automatic logic [6:0] flags;
    for (int i = 0; i < 7; i++) flags[i] = |status[i];
  endfunction : flags
  task automatic finish_test;
    $display("counts failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    #100us;
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    {sfr, endpoint_select, failures, comparisons, arst_n} = '0;
    void'($urandom(32'h4ca8));
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    foreach (regs[i]) begin
      acc(1'b1, regs[i], 8'h7f); // reserved bit 7 written as zero
      acc(1'b0, regs[i], 8'h00);
      chk("register", rexp[i], q);
    end
    flush(7'h7f);
    flush(7'h00);
    $display("test registers done");
    for (int e = 0; e < 7; e++) begin
      endpoint_select = 3'(e);
      n = 1 + $urandom % 8;
      repeat (n) begin
        d = 8'($urandom);
        usb_host_model_i.access(1'b1, 3'(e), d, q);
        mem[e][hp[e]++] = d;
      end
      usb_host_model_i.pulse(1'b0, 3'(e), 7'(n));
      cnt[e] = n;
      repeat (n) begin
        acc(1'b0, 8'hcf, 8'h00);
        chk("fifo read", mem[e][cp[e]++], q);
      end
      repeat (n) begin
        d = 8'($urandom);
        acc(1'b1, 8'hcf, d);
        mem[e][cp[e]++] = d;
      end
      repeat (n) begin
        usb_host_model_i.access(1'b0, 3'(e), 8'h00, q);
        chk("fifo write", mem[e][hp[e]++], q);
      end
    end
    for (int e = 0; e < 7; e++) begin
      endpoint_select = 3'(e);
      acc(1'b0, 8'he2, 8'h00);
      chk("count", 8'(cnt[e]), q);
    end
    n = $urandom % 7;
    endpoint_select = 3'(n);
    flush(7'(1 << n));
    acc(1'b1, 8'hcf, 8'h5a);
    acc(1'b0, 8'he2, 8'h00);
    chk("flushed count", 8'h00, q);
    flush(7'h00);
    usb_host_model_i.access(1'b0, 3'(n), 8'h00, q);
    chk("after flush", mem[n][0], q);
    $display("test fifo done");
    repeat (24) begin
      for (int i = 0; i < 7; i++) usb_host_model_i.status[i] = $urandom % 2 ? 5'($urandom) : 5'h00;
      en = 7'($urandom);
      acc(1'b1, 8'hc2, {1'b0, en});
      acc(1'b0, 8'hc2, 8'h00);
      chk("enable", {1'b0, en}, q);
      acc(1'b0, 8'hf8, 8'h00);
      chk("flags", {1'b0, flags()}, q);
      chk("irq", {7'h00, |(flags() & en)}, {7'h00, usb_irq});
    end
    for (int e = 0; e < 7; e++) usb_host_model_i.status[e] = 5'h00;
    for (int e = 0; e < 7; e++) begin
      usb_host_model_i.status[e] = 5'h17;
      usb_host_model_i.pulse(1'b1, 3'(e), 7'h00);
      @(negedge mclk);
      chk("setup", 8'h08, 8'(status[e]));
      acc(1'b0, 8'hf8, 8'h00);
      chk("setup flags", 8'((1 << (e + 1)) - 1), q);
    end
    $display("test events done");
    finish_test();
  end
endmodule : usb_ep_regs_tb_top

bind usb_ep_regs usb_ep_regs_assertions usb_ep_regs_assertions_i (.mclk, .arst_n, .sfr, .status,
  .setup_valid, .setup_ep, .sfr_rdata, .ep_flush, .setup_clear, .setup_clear_ep, .usb_irq);

// file: testbench/usb_host_model.sv
/* far-side engine model: status, packets, setups, fifo access.
   assumes the bench calls its tasks from falling-edge code. */
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic             mclk,
  input  wire logic             setup_clear,
  input  wire logic [2:0]       setup_clear_ep,
  input  wire logic [7:0]       eng_rdata,
  output usb_ep_pkg::ep_status_s status [usb_ep_pkg::EP_COUNT],
  output logic                  setup_valid,
  output logic [2:0]            setup_ep,
  output logic                  pkt_done,
  output logic [2:0]            pkt_ep,
  output logic [6:0]            pkt_len,
  output usb_ep_pkg::eng_req_s  eng
);
  // idle values
  initial begin
    status = '{default: '0};
    {setup_valid, setup_ep, pkt_done, pkt_ep, pkt_len} = '0;
    eng = '0;
  end
  // setup leaves only the setup flag
  always @(posedge mclk) if (setup_clear) status[setup_clear_ep] <= 5'h08;
  // one engine fifo access, noise on data when idle
  task automatic access(input bit w, input logic [2:0] ep, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge mclk);
    eng = {w, ~w, ep, d};
    @(negedge mclk);
    eng = {2'b00, ep, ~d};
    q = eng_rdata;
  endtask : access
  // packet end or setup pulse
  task automatic pulse(input bit s, input logic [2:0] ep, input logic [6:0] n);
    @(negedge mclk);
    {setup_valid, pkt_done, setup_ep, pkt_ep, pkt_len} = {s, ~s, ep, ep, n};
    @(negedge mclk);
    {setup_valid, pkt_done, pkt_len} = {2'b00, ~n};
  endtask : pulse
endmodule : usb_host_model
